/* rtl/csc_top.sv */
// Implementation choice: the AXI4-Lite slave port.
`include "csc_cfg.svh"

module csc_top #(
    parameter int unsigned SD_CYCLES = `CSC_SD_CYCLES
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [17:0] s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [17:0] s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic [5:0]  main_irq_source_low_i,
    input  wire logic [6:0]  main_irq_source_high_i,
    input  wire logic        main_irq_source_high_rd_i,
    input  wire logic        external_irq1_pin_i,
    output logic             processor_irq_line_a_o,
    output logic             processor_irq_line_b_o,
    output logic             hold_request_o,
    output logic             shutdown_o,
    output logic [7:0]       module_enable_o,
    output logic [3:0]       processor_clock_sel_o
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic csc_mapped(input logic [15:0] idx);
        csc_mapped = (idx == `CSC_IDX_MASK_LO) || (idx == `CSC_IDX_MASK_HI) ||
                     (idx == `CSC_IDX_CTRL) || (idx == `CSC_IDX_UNLOCK) ||
                     (idx == `CSC_IDX_MODEN);
    endfunction

    logic                 aw_rdy_r;
    logic                 w_rdy_r;
    logic                 ar_rdy_r;
    logic                 aw_held_r;
    logic                 w_held_r;
    logic [15:0]          aw_idx_r;
    logic [7:0]           w_data_r;
    logic                 w_lane_r;
    logic                 bvalid_r;
    logic [1:0]           bresp_r;
    logic                 rvalid_r;
    logic [1:0]           rresp_r;
    logic [31:0]          rdata_r;
    logic [7:0]           mask_lo_r;
    logic [7:0]           mask_hi_r;
    logic [7:0]           moden_r;
    csc_pkg::csc_ctrl_s   ctrl_r;
    csc_pkg::csc_ctrl_s   ctrl_nxt;
    csc_pkg::csc_ulk_e    ulk_r;
    csc_pkg::csc_ulk_e    ulk_nxt;
    logic                 shutdown_r;
    logic                 kp_hold_r;
    logic [16:0]          sd_cnt_r;
    logic                 pin_s1_r;
    logic                 pin_s2_r;
    logic                 irq_a_r;
    logic                 irq_b_r;
    logic                 hold_r;
    logic [7:0]           moden_out_r;
    logic [3:0]           clk_sel_r;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire        wr_do     = aw_held_r && w_held_r && !bvalid_r;
    wire        rd_do     = s_axi_arvalid_i && ar_rdy_r;
    wire [15:0] ar_idx    = s_axi_araddr_i[17:2];
    wire        wr_hit    = csc_mapped(aw_idx_r);
    wire        rd_hit    = csc_mapped(ar_idx) && (ar_idx != `CSC_IDX_UNLOCK);
    wire        wr_ctrl   = wr_do && (aw_idx_r == `CSC_IDX_CTRL);
    wire        wr_ulk    = wr_do && (aw_idx_r == `CSC_IDX_UNLOCK);
    wire        wr_st     = wr_do && w_lane_r;
    wire        wr_mlo    = wr_st && (aw_idx_r == `CSC_IDX_MASK_LO);
    wire        wr_mhi    = wr_st && (aw_idx_r == `CSC_IDX_MASK_HI);
    wire        wr_mod    = wr_st && (aw_idx_r == `CSC_IDX_MODEN);
    // a read in the same cycle as the final write still aborts
    wire        ctrl_commit = wr_ctrl && w_lane_r && !rd_do &&
                              (ulk_r == csc_pkg::CSC_ULK_THIRD);

    wire [7:0]  rd_byte =
        (ar_idx == `CSC_IDX_MASK_LO) ? (mask_lo_r & `CSC_WM_MASK_LO) :
        (ar_idx == `CSC_IDX_MASK_HI) ? (mask_hi_r & `CSC_WM_MASK_HI) :
        (ar_idx == `CSC_IDX_CTRL)    ? (ctrl_r & `CSC_WM_CTRL) :
        (ar_idx == `CSC_IDX_MODEN)   ? (moden_r & `CSC_WM_MODEN) : 8'h00;

    // ------------------------------------------------------------
    // interrupt gating
    // ------------------------------------------------------------
    // bypass holds from shutdown entry until the source is read after wake
    wire        kp_bypass = (shutdown_r || kp_hold_r) && !ctrl_r.pause_en;
    wire [6:0]  eff_mask_hi = mask_hi_r[6:0] |
                              {5'h00, kp_bypass, 1'h0};
    wire        irq_a = |(main_irq_source_low_i & mask_lo_r[5:0]);
    wire        irq_b = |(main_irq_source_high_i & eff_mask_hi);
    wire        any_irq = irq_a || irq_b;
    wire        sd_last = (sd_cnt_r == 17'(SD_CYCLES - 1));

    // ------------------------------------------------------------
    // unlock sequencer
    // ------------------------------------------------------------
    always_comb begin
        ulk_nxt = ulk_r;
        if (rd_do) begin
            ulk_nxt = csc_pkg::CSC_ULK_IDLE;
        end else if (wr_do) begin
            unique case (ulk_r)
                csc_pkg::CSC_ULK_IDLE: begin
                    ulk_nxt = wr_ulk ? csc_pkg::CSC_ULK_FIRST : csc_pkg::CSC_ULK_IDLE;
                end
                csc_pkg::CSC_ULK_FIRST: begin
                    ulk_nxt = wr_ctrl ? csc_pkg::CSC_ULK_SECOND :
                              wr_ulk  ? csc_pkg::CSC_ULK_FIRST : csc_pkg::CSC_ULK_IDLE;
                end
                csc_pkg::CSC_ULK_SECOND: begin
                    ulk_nxt = wr_ulk ? csc_pkg::CSC_ULK_THIRD : csc_pkg::CSC_ULK_IDLE;
                end
                csc_pkg::CSC_ULK_THIRD: begin
                    ulk_nxt = csc_pkg::CSC_ULK_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // control register next value
    // ------------------------------------------------------------
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (ctrl_commit) begin
            ctrl_nxt = csc_pkg::csc_ctrl_s'(w_data_r & `CSC_WM_CTRL);
        end
        if (any_irq) begin
            ctrl_nxt.shutdown = 1'b0;
            if (ctrl_r.auto_speed) begin
                ctrl_nxt.rate = 3'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            aw_rdy_r  <= 1'b1;
            w_rdy_r   <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_idx_r  <= 16'h0000;
            w_data_r  <= 8'h00;
            w_lane_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `CSC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && aw_rdy_r) begin
                aw_rdy_r  <= 1'b0;
                aw_held_r <= 1'b1;
                aw_idx_r  <= s_axi_awaddr_i[17:2];
            end
            if (s_axi_wvalid_i && w_rdy_r) begin
                w_rdy_r  <= 1'b0;
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata_i[7:0];
                w_lane_r <= s_axi_wstrb_i[0];
            end
            if (wr_do) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                aw_rdy_r  <= 1'b1;
                w_rdy_r   <= 1'b1;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? `CSC_RESP_OKAY : `CSC_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready_i) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ar_rdy_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r  <= `CSC_RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end else if (rd_do) begin
            ar_rdy_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r  <= rd_hit ? `CSC_RESP_OKAY : `CSC_RESP_SLVERR;
            rdata_r  <= {24'h000000, rd_byte};
        end else if (rvalid_r && s_axi_rready_i) begin
            rvalid_r <= 1'b0;
            ar_rdy_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers and shutdown timer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mask_lo_r <= `CSC_RST_MASK_LO;
            mask_hi_r <= `CSC_RST_MASK_HI;
            moden_r   <= `CSC_RST_MODEN;
            ctrl_r    <= csc_pkg::csc_ctrl_s'(`CSC_RST_CTRL);
            ulk_r     <= csc_pkg::CSC_ULK_IDLE;
        end else begin
            if (wr_mlo) mask_lo_r <= w_data_r & `CSC_WM_MASK_LO;
            if (wr_mhi) mask_hi_r <= w_data_r & `CSC_WM_MASK_HI;
            if (wr_mod) moden_r <= w_data_r & `CSC_WM_MODEN;
            ctrl_r <= ctrl_nxt;
            ulk_r  <= ulk_nxt;
        end
    end

    // the timer fires at the least time, well inside the longest bound
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sd_cnt_r   <= 17'h00000;
            shutdown_r <= 1'b0;
            kp_hold_r  <= 1'b0;
        end else begin
            if (ctrl_commit || !ctrl_nxt.shutdown || shutdown_r) begin
                sd_cnt_r <= 17'h00000;
            end else if (!sd_last) begin
                sd_cnt_r <= sd_cnt_r + 17'h00001;
            end
            if (shutdown_r && any_irq) begin
                shutdown_r <= 1'b0;
            end else if (sd_last && ctrl_nxt.shutdown && !ctrl_commit) begin
                shutdown_r <= 1'b1;
            end
            if (shutdown_r) begin
                kp_hold_r <= 1'b1;
            end else if (main_irq_source_high_rd_i) begin
                kp_hold_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pin_s1_r    <= 1'b0;
            pin_s2_r    <= 1'b0;
            irq_a_r     <= 1'b0;
            irq_b_r     <= 1'b0;
            hold_r      <= 1'b0;
            moden_out_r <= 8'h00;
            clk_sel_r   <= 4'h1;
        end else begin
            pin_s1_r    <= external_irq1_pin_i;
            pin_s2_r    <= pin_s1_r;
            irq_a_r     <= irq_a;
            irq_b_r     <= irq_b;
            hold_r      <= pin_s2_r && ctrl_r.pause_en;
            moden_out_r <= shutdown_r ? 8'h00 : moden_r;
            clk_sel_r   <= ctrl_r.dbl ? 4'h0 : {1'b0, ctrl_r.rate} + 4'h1;
        end
    end

    assign s_axi_awready_o        = aw_rdy_r;
    assign s_axi_wready_o         = w_rdy_r;
    assign s_axi_bvalid_o         = bvalid_r;
    assign s_axi_bresp_o          = bresp_r;
    assign s_axi_arready_o        = ar_rdy_r;
    assign s_axi_rvalid_o         = rvalid_r;
    assign s_axi_rresp_o          = rresp_r;
    assign s_axi_rdata_o          = rdata_r;
    assign processor_irq_line_a_o = irq_a_r;
    assign processor_irq_line_b_o = irq_b_r;
    assign hold_request_o         = hold_r;
    assign shutdown_o             = shutdown_r;
    assign module_enable_o        = moden_out_r;
    assign processor_clock_sel_o  = clk_sel_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_pin_hold;
        (external_irq1_pin_i && ctrl_r.pause_en)[*3];
    endsequence
    sequence s_unlock_tail;
        (ulk_r == csc_pkg::CSC_ULK_THIRD) && wr_do;
    endsequence

    a_line_a_gate: assert property (
        irq_a_r |-> $past(|(main_irq_source_low_i & mask_lo_r[5:0])))
        else $error("line a raised without an enabled source");
    a_low_rsvd_zero: assert property (
        rd_do && (ar_idx == `CSC_IDX_MASK_LO) |=> rdata_r[7:6] == 2'h0)
        else $error("reserved mask bits read nonzero");
    a_kp_bypass: assert property (
        shutdown_r && !ctrl_r.pause_en && main_irq_source_high_i[`CSC_BIT_KEYPAD] |=> irq_b_r)
        else $error("keypad did not reach line b in shutdown");
    a_ctrl_locked: assert property (
        wr_ctrl && (ulk_r != csc_pkg::CSC_ULK_THIRD) && !any_irq |=> $stable(ctrl_r))
        else $error("control changed without unlock");
    a_read_aborts: assert property (
        rd_do |=> ulk_r == csc_pkg::CSC_ULK_IDLE)
        else $error("read did not abort unlock");
    a_unlock_idle: assert property (
        s_unlock_tail |=> ulk_r == csc_pkg::CSC_ULK_IDLE)
        else $error("unlock not idle after final write");
    a_sd_entry: assert property (
        $rose(shutdown_r) |-> $past(sd_last) && $past(ctrl_r.shutdown))
        else $error("shutdown entered off the timer");
    a_irq_abort: assert property (
        any_irq |=> !ctrl_r.shutdown && !sd_last)
        else $error("interrupt did not abort shutdown");
    a_speed_up: assert property (
        any_irq && ctrl_r.auto_speed |=> ctrl_r.rate == 3'h0)
        else $error("speed-up did not clear rate");
    a_dbl_rate: assert property (
        ctrl_r.dbl |=> processor_clock_sel_o == 4'h0)
        else $error("double clock not selected");
    a_mod_gated: assert property (
        shutdown_r |=> module_enable_o == 8'h00)
        else $error("module enable live in shutdown");
    a_hold_path: assert property (
        s_pin_hold |=> hold_request_o)
        else $error("hold request not forwarded");

endmodule

/* rtl/csc_cfg.svh */
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
// Overview of operation
// - first mask bit one enables its source
// - first mask: drift, ext2, ext1, dtx, rxerr, rxfull
// - first mask bits seven and six read zero
// - second mask bit one enables its source
// - second mask: port1 groups, channel_match_sync_irq, serial, keypad, ext0
// - keypad mask ignored while shut down
// - keypad mask normal after wake and source read
// - pause input enable defeats keypad bypass
// - control reads free, writes only via unlock
// - any other access aborts unlock sequence
// - unlock address write only, data ignored
// - powerdown request enters shutdown after timer
// - unmasked interrupt aborts shutdown, clears request
// - write zero stops, write one restarts timer
// - request bit cleared on leaving shutdown
// - auto speed-up: interrupt selects full rate
// - rate field cleared by software or speed-up
// - rate code halves clock per step
// - clock double bypasses divider, rate ignored
// - pause enable routes irq1 pin to hold
// - module enables forced off during shutdown
// - scanner interrupts regardless of scanner enable
// - keypad activity wakes from shutdown unless pause enable is set

// register indices; byte address is four times the index
`define CSC_IDX_MASK_LO   16'hFFE2
`define CSC_IDX_MASK_HI   16'hFFE3
`define CSC_IDX_CTRL      16'hFFE9
`define CSC_IDX_UNLOCK    16'hFFEA
`define CSC_IDX_MODEN     16'hFFEB

`define CSC_RST_MASK_LO   8'h00
`define CSC_RST_MASK_HI   8'h00
`define CSC_RST_CTRL      8'h00
`define CSC_RST_MODEN     8'h00

`define CSC_WM_MASK_LO    8'h3F
`define CSC_WM_MASK_HI    8'h7F
`define CSC_WM_CTRL       8'hEF
`define CSC_WM_MODEN      8'hFB

`define CSC_BIT_KEYPAD    1

`define CSC_RESP_OKAY     2'h0
`define CSC_RESP_SLVERR   2'h2

`define CSC_CLK_NS        50
`define CSC_SD_MIN_NS     3560000
`define CSC_SD_MAX_NS     7120000
`define CSC_SD_CYCLES     ((`CSC_SD_MIN_NS + `CSC_CLK_NS - 1) / `CSC_CLK_NS)
`endif

/* rtl/csc_pkg.sv */
package csc_pkg;
    typedef enum logic [1:0] {
        CSC_ULK_IDLE,
        CSC_ULK_FIRST,
        CSC_ULK_SECOND,
        CSC_ULK_THIRD
    } csc_ulk_e;

    typedef struct packed {
        logic       shutdown;
        logic       auto_speed;
        logic       pause_en;
        logic       rsvd;
        logic       dbl;
        logic [2:0] rate;
    } csc_ctrl_s;
endpackage

/* bench/csc_core_model.sv */
`include "csc_cfg.svh"

module csc_core_model (
    input  wire logic        clk_i,
    output logic [17:0]      awaddr_o,
    output logic             awvalid_o,
    input  wire logic        awready_i,
    output logic [31:0]      wdata_o,
    output logic [3:0]       wstrb_o,
    output logic             wvalid_o,
    input  wire logic        wready_i,
    input  wire logic [1:0]  bresp_i,
    input  wire logic        bvalid_i,
    output logic             bready_o,
    output logic [17:0]      araddr_o,
    output logic             arvalid_o,
    input  wire logic        arready_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic [1:0]  rresp_i,
    input  wire logic        rvalid_i,
    output logic             rready_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        awaddr_o  = 18'h00000;
        awvalid_o = 1'b0;
        wdata_o   = 32'h00000000;
        wvalid_o  = 1'b0;
        wstrb_o   = 4'h0;
        bready_o  = 1'b0;
        araddr_o  = 18'h00000;
        arvalid_o = 1'b0;
        rready_o  = 1'b0;
    end

    // ----------------------------------------
    // bus tasks, one access at a time
    // ----------------------------------------
    // released lines get inverted so stale values never look valid
    // bready rises once both halves are taken, so back-to-back calls never touch it twice in one step
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] r,
                      input logic [3:0] s = 4'h1);
        logic aw_done;
        logic w_done;
        logic b_on;
        aw_done = 1'b0;
        w_done  = 1'b0;
        b_on    = 1'b0;
        awaddr_o  <= {idx, 2'b00};
        wdata_o   <= {24'h000000, d};
        wstrb_o   <= s;
        awvalid_o <= 1'b1;
        wvalid_o  <= 1'b1;
        while (!(aw_done && w_done && bvalid_i === 1'b1)) begin
            @(posedge clk_i);
            if (!aw_done && awready_i === 1'b1) begin
                aw_done = 1'b1;
                awvalid_o <= 1'b0;
                awaddr_o  <= ~awaddr_o;
            end
            if (!w_done && wready_i === 1'b1) begin
                w_done = 1'b1;
                wvalid_o <= 1'b0;
                wdata_o  <= ~wdata_o;
                wstrb_o  <= ~wstrb_o;
            end
            if (aw_done && w_done && !b_on) begin
                b_on = 1'b1;
                bready_o <= 1'b1;
            end
        end
        bready_o <= 1'b0;
        r = bresp_i;
    endtask

    task automatic rd(input logic [15:0] idx, output logic [7:0] d, output logic [1:0] r);
        araddr_o  <= {idx, 2'b00};
        arvalid_o <= 1'b1;
        do @(posedge clk_i); while (arready_i !== 1'b1);
        arvalid_o <= 1'b0;
        araddr_o  <= ~araddr_o;
        rready_o  <= 1'b1;
        do @(posedge clk_i); while (rvalid_i !== 1'b1);
        rready_o  <= 1'b0;
        d = rdata_i[7:0];
        r = rresp_i;
    endtask

    // the unlock writes carry junk data on purpose
    task automatic ctl(input logic [7:0] v);
        logic [1:0] r;
        wr(`CSC_IDX_UNLOCK, 8'hA5, r);
        wr(`CSC_IDX_CTRL, 8'h5A, r);
        wr(`CSC_IDX_UNLOCK, 8'h3C, r);
        wr(`CSC_IDX_CTRL, v, r);
    endtask
endmodule

/* bench/clock_shutdown_control_tb.sv */
`include "csc_cfg.svh"

module clock_shutdown_control_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int unsigned SD = 40;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  wstrb;
    logic        bready, rready;
    logic        awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
    logic [5:0]  src_lo = 6'h00;
    logic [6:0]  src_hi = 7'h00;
    logic        src_hi_rd = 1'b0;
    logic        pin1 = 1'b0;
    logic        irq_a, irq_b, hold, sd;
    logic [7:0]  men, d;
    logic [3:0]  csel;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          n;

    initial forever #25 clk = ~clk;

    csc_top #(.SD_CYCLES(SD)) dut (
        .sys_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .main_irq_source_low_i(src_lo), .main_irq_source_high_i(src_hi),
        .main_irq_source_high_rd_i(src_hi_rd), .external_irq1_pin_i(pin1),
        .processor_irq_line_a_o(irq_a), .processor_irq_line_b_o(irq_b), .hold_request_o(hold),
        .shutdown_o(sd), .module_enable_o(men), .processor_clock_sel_o(csel));

    csc_core_model core (
        .clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata),
        .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
        .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
        .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

    // ----------------------------------------
    // checks
    // ----------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [15:0] idx, input logic [7:0] exp, input logic [1:0] rexp);
        core.rd(idx, d, r);
        chk(d, exp);
        chk({6'h00, r}, {6'h00, rexp});
    endtask

    task automatic wchk(input logic [15:0] idx, input logic [7:0] v, input logic [3:0] s,
                        input logic [1:0] rexp);
        core.wr(idx, v, r, s);
        chk({6'h00, r}, {6'h00, rexp});
    endtask

    task automatic rc(input logic [7:0] exp);
        rchk(`CSC_IDX_CTRL, exp, `CSC_RESP_OKAY);
    endtask

    task automatic wait_sd(output int c);
        c = 0;
        while (sd !== 1'b1 && c < 4 * SD) begin
            @(posedge clk);
            c++;
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        cyc(4);
        rst_n <= 1'b1;
        cyc(1);
        rchk(`CSC_IDX_MASK_LO, `CSC_RST_MASK_LO, `CSC_RESP_OKAY);
        rchk(`CSC_IDX_MASK_HI, `CSC_RST_MASK_HI, `CSC_RESP_OKAY);
        rchk(`CSC_IDX_MODEN, `CSC_RST_MODEN, `CSC_RESP_OKAY);
        rc(`CSC_RST_CTRL);
        chk({4'h0, csel}, 8'h01);
        rchk(`CSC_IDX_UNLOCK, 8'h00, `CSC_RESP_SLVERR);
        rchk(16'hFFE0, 8'h00, `CSC_RESP_SLVERR);
        core.wr(`CSC_IDX_MASK_LO, 8'hFF, r);
        rchk(`CSC_IDX_MASK_LO, 8'h3F, `CSC_RESP_OKAY);
        core.wr(`CSC_IDX_MASK_HI, 8'hFF, r);
        rchk(`CSC_IDX_MASK_HI, 8'h7F, `CSC_RESP_OKAY);
        wchk(`CSC_IDX_MASK_LO, 8'h00, 4'h0, `CSC_RESP_OKAY);
        rchk(`CSC_IDX_MASK_LO, 8'h3F, `CSC_RESP_OKAY);
        wchk(`CSC_IDX_UNLOCK, 8'hFF, 4'h1, `CSC_RESP_OKAY);
        wchk(16'hFFE0, 8'h00, 4'h1, `CSC_RESP_SLVERR);
        for (int i = 0; i < 6; i++) begin
            core.wr(`CSC_IDX_MASK_LO, 8'h01 << i, r);
            src_lo <= ~(6'h01 << i);
            cyc(3);
            chk({7'h00, irq_a}, 8'h00);
            src_lo <= 6'h01 << i;
            cyc(3);
            chk({7'h00, irq_a}, 8'h01);
        end
        src_lo <= 6'h00;
        for (int i = 0; i < 7; i++) begin
            core.wr(`CSC_IDX_MASK_HI, 8'h01 << i, r);
            src_hi <= ~(7'h01 << i);
            cyc(3);
            chk({7'h00, irq_b}, 8'h00);
            src_hi <= 7'h01 << i;
            cyc(3);
            chk({7'h00, irq_b}, 8'h01);
        end
        src_hi <= 7'h00;
        core.wr(`CSC_IDX_MASK_HI, 8'h00, r);
        core.wr(`CSC_IDX_MASK_LO, 8'h01, r);
        core.wr(`CSC_IDX_CTRL, 8'h07, r);
        rc(8'h00);
        for (int i = 0; i < 8; i++) begin
            core.ctl(8'(i));
            cyc(2);
            chk({4'h0, csel}, 8'(i + 1));
        end
        core.ctl(8'h1F);
        cyc(2);
        chk({4'h0, csel}, 8'h00);
        rc(8'h0F);
        core.ctl(8'h04);
        core.wr(`CSC_IDX_CTRL, 8'h06, r);
        rc(8'h04);
        core.wr(`CSC_IDX_UNLOCK, 8'h00, r);
        core.wr(`CSC_IDX_CTRL, 8'h00, r);
        core.rd(`CSC_IDX_MASK_LO, d, r);
        core.wr(`CSC_IDX_UNLOCK, 8'h00, r);
        core.wr(`CSC_IDX_CTRL, 8'h02, r);
        rc(8'h04);
        core.ctl(8'h47);
        cyc(2);
        chk({4'h0, csel}, 8'h08);
        src_lo <= 6'h01;
        cyc(1);
        src_lo <= 6'h00;
        cyc(3);
        chk({4'h0, csel}, 8'h01);
        rc(8'h40);
        core.ctl(8'h80);
        cyc(5);
        src_lo <= 6'h01;
        cyc(2);
        src_lo <= 6'h00;
        rc(8'h00);
        cyc(2 * SD);
        chk({7'h00, sd}, 8'h00);
        core.ctl(8'h80);
        cyc(5);
        core.ctl(8'h00);
        cyc(2 * SD);
        chk({7'h00, sd}, 8'h00);
        core.wr(`CSC_IDX_MODEN, 8'hFF, r);
        rchk(`CSC_IDX_MODEN, 8'hFB, `CSC_RESP_OKAY);
        // second request lands before the first timer would have fired
        core.ctl(8'h80);
        cyc(10);
        core.ctl(8'h80);
        wait_sd(n);
        chk(8'(n >= SD - 4 && n <= 2 * SD), 8'h01);
        // module enables drop one cycle after the shutdown flag
        cyc(1);
        chk(men, 8'h00);
        src_hi <= 7'h02;
        cyc(2);
        src_hi <= 7'h00;
        cyc(4);
        chk({7'h00, sd}, 8'h00);
        chk(men, 8'hFB);
        rc(8'h00);
        src_hi <= 7'h02;
        cyc(3);
        chk({7'h00, irq_b}, 8'h01);
        src_hi <= 7'h00;
        src_hi_rd <= 1'b1;
        cyc(1);
        src_hi_rd <= 1'b0;
        src_hi <= 7'h02;
        cyc(3);
        chk({7'h00, irq_b}, 8'h00);
        src_hi <= 7'h00;
        pin1 <= 1'b1;
        cyc(5);
        chk({7'h00, hold}, 8'h00);
        core.ctl(8'h20);
        cyc(5);
        chk({7'h00, hold}, 8'h01);
        pin1 <= 1'b0;
        core.ctl(8'hA0);
        wait_sd(n);
        src_hi <= 7'h02;
        cyc(5);
        chk({7'h00, sd}, 8'h01);
        src_hi <= 7'h00;
        src_lo <= 6'h01;
        cyc(2);
        src_lo <= 6'h00;
        cyc(4);
        chk({7'h00, sd}, 8'h00);
        rc(8'h20);
        end_of_test();
    end
endmodule
